// ===== host_link_status_regs.svh
// Register offsets, field positions, reset values and status codes of the host link status block
`ifndef HOST_LINK_STATUS_REGS_SVH
`define HOST_LINK_STATUS_REGS_SVH

// ==========================================================
// Register byte offsets
`define REG_CONFIG 4'h0
`define REG_FLAGS 4'h4
`define REG_ERR_CLEAR 4'h8
`define REG_CODE_QUERY 4'hC

// ==========================================================
// Config fields
`define CFG_RTS_MODE_LSB 0
`define CFG_RTS_MODE_MSB 1
`define CFG_DROP_DTR 2
`define CFG_XON_XOFF 3
`define CFG_REV_CHAN_EN 4
`define CFG_REV_CHAN_POL 5
`define CFG_STOP_XMIT 6
`define CFG_STOP_CODE 7
`define CFG_STOP_SEQ 8
`define CFG_NL_MARGIN 9
`define CFG_SUB_LSB 16
`define CFG_SUB_MSB 23
`define CONFIG_RESET 32'h0000_0000
`define CONFIG_MASK 32'h00FF_03FF

// ==========================================================
// Flag bit positions
`define FLG_XMIT_ERR 0
`define FLG_CODE_ERR 1
`define FLG_SEQ_ERR 2
`define FLG_OVERFLOW 3
`define FLG_MARGIN 4
`define FLG_TAB_LOAD 5
`define FLG_VFI_LOAD 6
`define FLG_STOP 8
`define FLG_ERR_STOP 9
`define FLG_DTR 10
`define FLG_REV_CHAN 11
`define FLG_CTS_WAIT 12

// ==========================================================
// Status codes
`define CODE_RTS_WAIT 8'h57
`define CODE_RTS_NOWAIT 8'h58
`define CODE_RTS_ON_WAIT 8'h59
`define CODE_RTS_ON_NOWAIT 8'h5A
`define CODE_DROP_DTR 8'h5D
`define CODE_XON_XOFF 8'h5E
`define CODE_REV_FULL 8'h5F
`define CODE_REV_EMPTY 8'h60
`define CODE_XMIT_ERR 8'h62
`define CODE_CODE_ERR 8'h63
`define CODE_SEQ_ERR 8'h64
`define CODE_OVERFLOW 8'h65
`define CODE_MARGIN 8'h66
`define CODE_TAB_LOAD 8'h67
`define CODE_VFI_LOAD 8'h68
`define CODE_DTR 8'h69
`define CODE_STOP 8'h6A
`define CODE_ERR_STOP 8'h6B

// ==========================================================
// Flow characters
`define CHAR_XON 8'h11
`define CHAR_XOFF 8'h13

`endif

// ===== host_link_status_pkg.sv
// Types for the host link status block
package host_link_status_pkg;
   typedef enum logic [1:0] {
      RTS_WAIT = 2'h0,
      RTS_NOWAIT = 2'h1,
      RTS_ON_WAIT = 2'h2,
      RTS_ON_NOWAIT = 2'h3
   } rts_mode_t;

   typedef enum logic [2:0] {
      ST_RUN = 3'b001,
      ST_STOP = 3'b010,
      ST_ERR_STOP = 3'b100
   } run_state_t;
endpackage : host_link_status_pkg

// ===== host_link_status.sv
// Host serial link handshake, error flagging and status code reporting
//
// Behaviour
// - RTS asserted, send waits for CTS
// - Other RTS modes, each own code
// - Drop DTR while operator stop, if enabled
// - XON/XOFF pacing, reported; host must obey
// - Reverse line on when buffer almost full
// - Alternate polarity: on when almost empty
// - Selected link errors halt, flag, allow clear
// - Overflow flagged, later data discarded
// - Margin overrun flagged when wrap disabled
// - Wrap enabled: next line, no error
// - Terminal ready code while DTR on
// - Stop code until printing resumes
// - Error stop code with specific error
// - Invalid code with stop option halts
// - Substitute option replaces code, continues
`timescale 1ns/100ps
`include "host_link_status_regs.svh"

module host_link_status #(
   parameter int BUF_DEPTH = 2048,
   parameter int ALMOST_FULL = 1792,
   parameter int ALMOST_EMPTY = 256
) (
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic clk_en_in,
   // Avalon-MM slave
   input wire logic [3:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // Modem pins
   input wire logic cts_in,
   output logic rts_out,
   output logic dtr_out,
   output logic rev_chan_out,
   // Transmitter side
   input wire logic tx_req_in,
   output logic tx_allow_out,
   output logic flow_char_valid_out,
   output logic [7:0] flow_char_out,
   input wire logic flow_char_ack_in,
   // Receive stream
   input wire logic rx_valid_in,
   input wire logic [7:0] rx_data_in,
   input wire logic rx_invalid_code_in,
   input wire logic rx_invalid_seq_in,
   input wire logic rx_xmit_err_in,
   input wire logic [$clog2(BUF_DEPTH+1)-1:0] buf_level_in,
   output logic wr_valid_out,
   output logic [7:0] wr_data_out,
   // Line formatting events
   input wire logic margin_over_in,
   output logic new_line_out,
   input wire logic tab_load_bad_in,
   input wire logic vfi_load_bad_in,
   // Operator panel
   input wire logic start_stop_btn_in,
   input wire logic buf_clear_btn_in,
   output logic buf_clear_en_out,
   output logic buf_clear_out,
   output logic printing_out,
   output host_link_status_pkg::run_state_t run_state_out
);
   import host_link_status_pkg::*;

   localparam int LW = $clog2(BUF_DEPTH + 1);

   logic [31:0] config_q;
   logic [12:0] err_flags;
   run_state_t state;
   logic [2:0] cts_sync;
   logic [2:0] btn_sync;
   logic [2:0] clr_sync;
   logic cts_level;
   logic btn_level;
   logic clr_level;
   logic btn_prev;
   logic clr_prev;
   logic xoff_sent;
   logic overflowed;
   logic [7:0] query_code;
   logic wr_acc;
   logic rd_acc;
   logic any_err;
   logic halt_err;
   logic clear_req;
   logic [12:0] set_err;
   logic [12:0] flags_view;
   rts_mode_t rts_mode;

   function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge_bytes

   // ==========================================================
   // Bus slave: one wait cycle on reads, writes take at once
   logic rd_pend;
   assign wr_acc = avs_write_in && clk_en_in;
   assign rd_acc = avs_read_in && clk_en_in && rd_pend;
   assign avs_waitrequest_out = (avs_read_in && !rd_pend) || !clk_en_in;

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rd_pend <= 1'b0;
      end else if (clk_en_in) begin
         rd_pend <= avs_read_in && !rd_pend;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         config_q <= `CONFIG_RESET;
      end else if (wr_acc && avs_address_in == `REG_CONFIG) begin
         config_q <= merge_bytes(config_q, avs_writedata_in, avs_byteenable_in) & `CONFIG_MASK;
      end
   end

   assign clear_req = wr_acc && avs_address_in == `REG_ERR_CLEAR && avs_writedata_in[0];

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         query_code <= 8'h00;
      end else if (wr_acc && avs_address_in == `REG_CODE_QUERY) begin
         query_code <= avs_writedata_in[7:0];
      end
   end

   // Code query answers 1 when the named condition is present
   function automatic logic code_active(input logic [7:0] c, input logic [31:0] cfg, input logic [12:0] f);
      logic r;
      r = 1'b0;
      case (c)
         `CODE_RTS_WAIT: r = cfg[`CFG_RTS_MODE_MSB:`CFG_RTS_MODE_LSB] == RTS_WAIT;
         `CODE_RTS_NOWAIT: r = cfg[`CFG_RTS_MODE_MSB:`CFG_RTS_MODE_LSB] == RTS_NOWAIT;
         `CODE_RTS_ON_WAIT: r = cfg[`CFG_RTS_MODE_MSB:`CFG_RTS_MODE_LSB] == RTS_ON_WAIT;
         `CODE_RTS_ON_NOWAIT: r = cfg[`CFG_RTS_MODE_MSB:`CFG_RTS_MODE_LSB] == RTS_ON_NOWAIT;
         `CODE_DROP_DTR: r = cfg[`CFG_DROP_DTR];
         `CODE_XON_XOFF: r = cfg[`CFG_XON_XOFF];
         `CODE_REV_FULL: r = cfg[`CFG_REV_CHAN_EN] && !cfg[`CFG_REV_CHAN_POL];
         `CODE_REV_EMPTY: r = cfg[`CFG_REV_CHAN_EN] && cfg[`CFG_REV_CHAN_POL];
         `CODE_XMIT_ERR: r = f[`FLG_XMIT_ERR];
         `CODE_CODE_ERR: r = f[`FLG_CODE_ERR];
         `CODE_SEQ_ERR: r = f[`FLG_SEQ_ERR];
         `CODE_OVERFLOW: r = f[`FLG_OVERFLOW];
         `CODE_MARGIN: r = f[`FLG_MARGIN];
         `CODE_TAB_LOAD: r = f[`FLG_TAB_LOAD];
         `CODE_VFI_LOAD: r = f[`FLG_VFI_LOAD];
         `CODE_DTR: r = f[`FLG_DTR];
         `CODE_STOP: r = f[`FLG_STOP];
         `CODE_ERR_STOP: r = f[`FLG_ERR_STOP];
         default: r = 1'b0;
      endcase
      return r;
   endfunction : code_active

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         avs_readdata_out <= 32'h0000_0000;
      end else if (clk_en_in && avs_read_in && !rd_pend) begin
         case (avs_address_in)
            `REG_CONFIG: avs_readdata_out <= config_q;
            `REG_FLAGS: avs_readdata_out <= {19'h0_0000, flags_view};
            `REG_CODE_QUERY: avs_readdata_out <= {23'h00_0000, code_active(query_code, config_q, flags_view),
                                                  query_code};
            default: avs_readdata_out <= 32'h0000_0000;
         endcase
      end
   end

   // ==========================================================
   // Pin synchronisers: change counts once stages two and three agree
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cts_sync <= 3'h0;
         btn_sync <= 3'h0;
         clr_sync <= 3'h0;
         cts_level <= 1'b0;
         btn_level <= 1'b0;
         clr_level <= 1'b0;
      end else if (clk_en_in) begin
         cts_sync <= {cts_sync[1:0], cts_in};
         btn_sync <= {btn_sync[1:0], start_stop_btn_in};
         clr_sync <= {clr_sync[1:0], buf_clear_btn_in};
         if (cts_sync[1] == cts_sync[2]) begin
            cts_level <= cts_sync[2];
         end
         if (btn_sync[1] == btn_sync[2]) begin
            btn_level <= btn_sync[2];
         end
         if (clr_sync[1] == clr_sync[2]) begin
            clr_level <= clr_sync[2];
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         btn_prev <= 1'b0;
         clr_prev <= 1'b0;
      end else if (clk_en_in) begin
         btn_prev <= btn_level;
         clr_prev <= clr_level;
      end
   end

   // ==========================================================
   // Error flags: set wins over clear
   logic margin_err;
   assign rts_mode = rts_mode_t'(config_q[`CFG_RTS_MODE_MSB:`CFG_RTS_MODE_LSB]);
   assign margin_err = margin_over_in && !config_q[`CFG_NL_MARGIN];
   assign new_line_out = margin_over_in && config_q[`CFG_NL_MARGIN];
   assign set_err = {6'h00, vfi_load_bad_in, tab_load_bad_in, margin_err,
                     rx_valid_in && buf_level_in >= LW'(BUF_DEPTH),
                     rx_valid_in && rx_invalid_seq_in,
                     rx_valid_in && rx_invalid_code_in,
                     rx_valid_in && rx_xmit_err_in};
   assign any_err = |err_flags[6:0];
   // Only stop-selected link errors halt; other errors always halt
   assign halt_err = (err_flags[`FLG_XMIT_ERR] && config_q[`CFG_STOP_XMIT])
                  || (err_flags[`FLG_CODE_ERR] && config_q[`CFG_STOP_CODE])
                  || (err_flags[`FLG_SEQ_ERR] && config_q[`CFG_STOP_SEQ])
                  || (|err_flags[6:3]);

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         err_flags <= 13'h0000;
      end else if (clk_en_in) begin
         err_flags <= (clear_req || (buf_clear_out) ? 13'h0000 : err_flags) | set_err;
      end
   end

   // Overflow discard lasts until the buffer is cleared or the error clear register is written
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         overflowed <= 1'b0;
      end else if (clk_en_in) begin
         if (set_err[`FLG_OVERFLOW]) begin
            overflowed <= 1'b1;
         end else if (buf_clear_out || clear_req) begin
            overflowed <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Run state
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state <= ST_RUN;
      end else if (clk_en_in) begin
         case (state)
            ST_RUN: begin
               if (halt_err) begin
                  state <= ST_ERR_STOP;
               end else if (btn_level && !btn_prev) begin
                  state <= ST_STOP;
               end
            end
            ST_STOP: begin
               if (halt_err) begin
                  state <= ST_ERR_STOP;
               end else if (btn_level && !btn_prev) begin
                  state <= ST_RUN;
               end
            end
            ST_ERR_STOP: begin
               if (!halt_err && !any_err) begin
                  state <= ST_STOP;
               end
            end
            default: state <= ST_RUN;
         endcase
      end
   end

   assign run_state_out = state;
   assign printing_out = state == ST_RUN;
   assign buf_clear_en_out = state != ST_RUN;
   assign buf_clear_out = buf_clear_en_out && clr_level && !clr_prev && clk_en_in;

   // ==========================================================
   // Modem lines
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rts_out <= 1'b0;
         dtr_out <= 1'b0;
         rev_chan_out <= 1'b0;
      end else if (clk_en_in) begin
         rts_out <= rts_mode inside {RTS_ON_WAIT, RTS_ON_NOWAIT} || tx_req_in;
         dtr_out <= !(config_q[`CFG_DROP_DTR] && state != ST_RUN);
         if (!config_q[`CFG_REV_CHAN_EN]) begin
            rev_chan_out <= 1'b0;
         end else if (!config_q[`CFG_REV_CHAN_POL]) begin
            rev_chan_out <= buf_level_in >= LW'(ALMOST_FULL);
         end else begin
            rev_chan_out <= buf_level_in <= LW'(ALMOST_EMPTY);
         end
      end
   end

   assign tx_allow_out = tx_req_in && rts_out
                      && (cts_level || rts_mode inside {RTS_NOWAIT, RTS_ON_NOWAIT});

   assign flags_view = {!cts_level && rts_mode inside {RTS_WAIT, RTS_ON_WAIT},
                        rev_chan_out, dtr_out,
                        state == ST_ERR_STOP, state == ST_STOP,
                        1'b0, err_flags[6:0]};

   // ==========================================================
   // XON/XOFF pacing with hysteresis on buffer level
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         xoff_sent <= 1'b0;
         flow_char_valid_out <= 1'b0;
         flow_char_out <= 8'h00;
      end else if (clk_en_in) begin
         if (flow_char_valid_out) begin
            if (flow_char_ack_in) begin
               flow_char_valid_out <= 1'b0;
            end
         end else if (config_q[`CFG_XON_XOFF]) begin
            if (!xoff_sent && buf_level_in >= LW'(ALMOST_FULL)) begin
               flow_char_out <= `CHAR_XOFF;
               flow_char_valid_out <= 1'b1;
               xoff_sent <= 1'b1;
            end else if (xoff_sent && buf_level_in <= LW'(ALMOST_EMPTY)) begin
               flow_char_out <= `CHAR_XON;
               flow_char_valid_out <= 1'b1;
               xoff_sent <= 1'b0;
            end
         end else begin
            xoff_sent <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Received data to buffer, with substitution and discard
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_valid_out <= 1'b0;
         wr_data_out <= 8'h00;
      end else if (clk_en_in) begin
         wr_valid_out <= rx_valid_in && !overflowed && !set_err[`FLG_OVERFLOW];
         if (rx_valid_in && rx_invalid_code_in && !config_q[`CFG_STOP_CODE]) begin
            wr_data_out <= config_q[`CFG_SUB_MSB:`CFG_SUB_LSB];
         end else if (rx_valid_in) begin
            wr_data_out <= rx_data_in;
         end
      end
   end
endmodule : host_link_status

// ===== host_link_status_props.sv
// Checker of host link status port relations
`timescale 1ns/100ps
`include "host_link_status_regs.svh"
module host_link_status_props #(
   parameter int BUF_DEPTH = 2048
) (
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic clk_en_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic avs_waitrequest_out,
   input wire logic rts_out,
   input wire logic tx_req_in,
   input wire logic tx_allow_out,
   input wire logic flow_char_valid_out,
   input wire logic [7:0] flow_char_out,
   input wire logic flow_char_ack_in,
   input wire logic rx_valid_in,
   input wire logic [$clog2(BUF_DEPTH+1)-1:0] buf_level_in,
   input wire logic wr_valid_out,
   input wire logic margin_over_in,
   input wire logic new_line_out,
   input wire logic buf_clear_en_out,
   input wire logic buf_clear_out,
   input wire logic printing_out,
   input wire host_link_status_pkg::run_state_t run_state_out
);
   import host_link_status_pkg::*;
   // ====================
   // Port relations
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   chk_allow_gate: assert property (tx_allow_out |-> tx_req_in && rts_out)
      else $error("tx allowed without request or rts");
   chk_write_nowait: assert property (avs_write_in && clk_en_in |-> !avs_waitrequest_out)
      else $error("write stalled");
   chk_read_answer: assert property (avs_read_in && avs_waitrequest_out && clk_en_in ##1
      avs_read_in && clk_en_in |-> !avs_waitrequest_out) else $error("read not answered");
   chk_overflow_drop: assert property (rx_valid_in && buf_level_in >= BUF_DEPTH |=> !wr_valid_out)
      else $error("byte kept after overflow");
   chk_flow_hold: assert property (flow_char_valid_out && !flow_char_ack_in
      |=> flow_char_valid_out && $stable(flow_char_out)) else $error("flow char dropped");
   chk_flow_code: assert property (flow_char_valid_out
      |-> flow_char_out == `CHAR_XON || flow_char_out == `CHAR_XOFF) else $error("bad flow char");
   chk_clear_enable: assert property (buf_clear_en_out != printing_out)
      else $error("clear enable wrong");
   chk_clear_gate: assert property (buf_clear_out |-> buf_clear_en_out)
      else $error("clear while running");
   chk_run_state: assert property (printing_out == (run_state_out == ST_RUN) && $onehot(run_state_out))
      else $error("run state inconsistent");
   chk_new_line: assert property (new_line_out |-> margin_over_in)
      else $error("new line without margin event");
endmodule : host_link_status_props

bind host_link_status host_link_status_props #(.BUF_DEPTH(BUF_DEPTH)) i_props (.clk_sys_in, .rst_n_in,
   .clk_en_in, .avs_read_in, .avs_write_in, .avs_waitrequest_out, .rts_out, .tx_req_in, .tx_allow_out,
   .flow_char_valid_out, .flow_char_out, .flow_char_ack_in, .rx_valid_in, .buf_level_in, .wr_valid_out,
   .margin_over_in, .new_line_out, .buf_clear_en_out, .buf_clear_out, .printing_out, .run_state_out);

// ===== host_model.sv
// Host computer on the far side of the serial link
`timescale 1ns/100ps
`include "host_link_status_regs.svh"
module host_model (
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic slow_in,
   input wire logic rts_in,
   input wire logic flow_char_valid_in,
   input wire logic [7:0] flow_char_in,
   output logic cts_out,
   output logic flow_char_ack_out,
   output logic paused_out
);
   // ====================
   // Handshake answers
   logic [2:0] dly;
   logic ack_q;
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         dly <= 3'h0;
         ack_q <= 1'b0;
         paused_out <= 1'b0;
      end else begin
         dly <= {dly[1:0], rts_in};
         ack_q <= flow_char_valid_in && !ack_q;
         if (flow_char_valid_in && flow_char_ack_out) begin
            paused_out <= (flow_char_in == `CHAR_XOFF);
         end
      end
   end
   // Slow host lags CTS and acks every other cycle
   assign cts_out = slow_in ? dly[2] : rts_in;
   assign flow_char_ack_out = flow_char_valid_in && (!slow_in || ack_q);
endmodule : host_model

// ===== testbench.sv
// Self-checking bench of the host link status block
`timescale 1ns/100ps
`include "host_link_status_regs.svh"
module testbench;
   import host_link_status_pkg::*;
   logic clk_sys_in = 1'b0, rst_n_in = 1'b0, rd_r = 1'b0, wr_r = 1'b0, tx_req = 1'b0, rxv = 1'b0;
   logic [2:0] rxe = 3'h0;
   logic mo = 1'b0, tb = 1'b0, vb = 1'b0, ssb = 1'b0, bcb = 1'b0, slow = 1'b1, nl_seen = 1'b0, en = 1'b1;
   logic [3:0] adr = 4'h0;
   logic [31:0] wdat = 32'h0, rdat, v;
   logic [7:0] rxd = 8'h0, last_wd = 8'h0, last_fc = 8'h0, rnd = 8'h0;
   logic [11:0] lvl = 12'h0;
   logic waitreq, cts, rts, dtr, rev, tx_allow, fcv, fack, wv, nl, bce, bco, pr, paused;
   logic [7:0] fc, wd;
   run_state_t rs;
   int n_errors = 0, n_tests = 0, n_wr = 0, cyc = 0, k;
   logic [31:0] cfg_t[4] = '{32'h4, 32'h8, 32'h10, 32'h30};
   logic [7:0] code_t[4] = '{`CODE_DROP_DTR, `CODE_XON_XOFF, `CODE_REV_FULL, `CODE_REV_EMPTY};
   logic [2:0] err_t[3] = '{3'b100, 3'b001, 3'b010};

   host_link_status i_dut (.clk_sys_in, .rst_n_in, .clk_en_in(en), .avs_address_in(adr),
      .avs_read_in(rd_r), .avs_write_in(wr_r), .avs_writedata_in(wdat), .avs_byteenable_in(4'hF),
      .avs_readdata_out(rdat), .avs_waitrequest_out(waitreq), .cts_in(cts), .rts_out(rts), .dtr_out(dtr),
      .rev_chan_out(rev), .tx_req_in(tx_req), .tx_allow_out(tx_allow), .flow_char_valid_out(fcv),
      .flow_char_out(fc), .flow_char_ack_in(fack), .rx_valid_in(rxv), .rx_data_in(rxd),
      .rx_invalid_code_in(rxe[0]), .rx_invalid_seq_in(rxe[1]), .rx_xmit_err_in(rxe[2]), .buf_level_in(lvl),
      .wr_valid_out(wv), .wr_data_out(wd), .margin_over_in(mo), .new_line_out(nl), .tab_load_bad_in(tb),
      .vfi_load_bad_in(vb), .start_stop_btn_in(ssb), .buf_clear_btn_in(bcb), .buf_clear_en_out(bce),
      .buf_clear_out(bco), .printing_out(pr), .run_state_out(rs));
   host_model i_host (.clk_sys_in, .rst_n_in, .slow_in(slow), .rts_in(rts), .flow_char_valid_in(fcv),
      .flow_char_in(fc), .cts_out(cts), .flow_char_ack_out(fack), .paused_out(paused));

   // ====================
   // Clock, monitors, timeout
   initial forever #4 clk_sys_in = ~clk_sys_in;
   always @(posedge clk_sys_in) begin
      cyc++;
      if (wv === 1'b1) begin
         last_wd <= wd;
         n_wr++;
      end
      if (fcv === 1'b1 && fack === 1'b1) last_fc <= fc;
      if (nl === 1'b1) nl_seen <= 1'b1;
      if (cyc == 20000) begin
         n_errors++;
         print_verdict();
      end
   end

   // ====================
   // Helpers
   function automatic logic [31:0] code_word(input logic [7:0] c, input logic act);
      return {23'h0, act, c};
   endfunction : code_word
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc_wait(input int n);
      repeat (n) @(posedge clk_sys_in);
   endtask : cyc_wait
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      adr <= a;
      wdat <= d;
      wr_r <= w;
      rd_r <= !w;
      do @(posedge clk_sys_in); while (waitreq !== 1'b0);
      v = rdat;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
   endtask : bus
   task automatic q(input logic [7:0] c, input logic act);
      bus(1'b1, `REG_CODE_QUERY, {24'h0, c});
      bus(1'b0, `REG_CODE_QUERY, 32'h0);
      chk(v & 32'h1FF, code_word(c, act));
   endtask : q
   task automatic flags(input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, `REG_FLAGS, 32'h0);
      chk(v & m, e);
   endtask : flags
   task automatic rx(input logic [7:0] d, input logic [2:0] e);
      @(posedge clk_sys_in);
      rxv <= 1'b1;
      rxd <= d;
      rxe <= e;
      @(posedge clk_sys_in);
      rxv <= 1'b0;
      rxe <= 3'h0;
      cyc_wait(4);
   endtask : rx
   task automatic btn(input logic clr);
      @(posedge clk_sys_in);
      if (clr) bcb <= 1'b1; else ssb <= 1'b1;
      cyc_wait(6);
      bcb <= 1'b0;
      ssb <= 1'b0;
      cyc_wait(6);
   endtask : btn
   task automatic recover(input logic by_btn);
      if (by_btn) btn(1'b1); else bus(1'b1, `REG_ERR_CLEAR, 32'h1);
      cyc_wait(4);
      chk(32'(rs), 32'(ST_STOP));
      btn(1'b0);
      chk(32'(rs), 32'(ST_RUN));
   endtask : recover
   task automatic print_verdict();
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict

   // ====================
   // Scenarios
   initial begin
      void'($urandom(32'h195D));
      cyc_wait(20);
      rst_n_in <= 1'b1;
      cyc_wait(3);
      chk(32'(dtr), 32'h1);
      bus(1'b0, `REG_CONFIG, 32'h0);
      chk(v, `CONFIG_RESET);
      bus(1'b0, 4'h2, 32'h0);
      chk(v, 32'h0);
      q(`CODE_DTR, 1'b1);
      $display("reset done");
      tx_req <= 1'b1;
      // RTS rises one clock later, CTS lags through host and synchroniser
      cyc_wait(2);
      chk({30'h0, rts, tx_allow}, 32'h2);
      for (k = 0; k < 4; k++) begin
         bus(1'b1, `REG_CONFIG, 32'(k));
         q(8'(`CODE_RTS_WAIT + k), 1'b1);
         cyc_wait(8);
         chk({30'h0, rts, tx_allow}, 32'h3);
      end
      for (k = 0; k < 4; k++) begin
         bus(1'b1, `REG_CONFIG, cfg_t[k]);
         q(code_t[k], 1'b1);
      end
      $display("mode codes done");
      bus(1'b1, `REG_CONFIG, 32'h10);
      lvl <= 12'd2000;
      cyc_wait(5);
      chk(32'(rev), 32'h1);
      lvl <= 12'd100;
      cyc_wait(5);
      chk(32'(rev), 32'h0);
      bus(1'b1, `REG_CONFIG, 32'h30);
      cyc_wait(5);
      chk(32'(rev), 32'h1);
      bus(1'b1, `REG_CONFIG, 32'h8);
      lvl <= 12'd2000;
      cyc_wait(30);
      chk({last_fc, 7'h0, paused}, {`CHAR_XOFF, 8'h1});
      slow <= 1'b0;
      lvl <= 12'd100;
      cyc_wait(30);
      chk({last_fc, 7'h0, paused}, {`CHAR_XON, 8'h0});
      $display("flow done");
      for (k = 0; k < 3; k++) begin
         bus(1'b1, `REG_CONFIG, 32'h40 << k);
         rx(8'h41, err_t[k]);
         chk({29'h0, rs} | 32'(bce) << 8, 32'h104);
         q(8'(`CODE_XMIT_ERR + k), 1'b1);
         q(`CODE_ERR_STOP, 1'b1);
         flags(32'h7, 32'h1 << k);
         recover(k == 0);
      end
      bus(1'b1, `REG_CONFIG, 32'h00A5_0000);
      rx(8'h41, 3'b001);
      chk({last_wd, 24'(rs)}, {8'hA5, 24'(ST_RUN)});
      bus(1'b1, `REG_ERR_CLEAR, 32'h1);
      $display("link errors done");
      bus(1'b1, `REG_CONFIG, 32'h0);
      k = n_wr;
      lvl <= 12'd2048;
      rx(8'h55, 3'h0);
      lvl <= 12'd0;
      rx(8'h56, 3'h0);
      chk(32'(n_wr - k), 32'h0);
      flags(32'h8, 32'h8);
      recover(1'b0);
      @(posedge clk_sys_in);
      {mo, tb, vb} <= 3'b111;
      @(posedge clk_sys_in);
      {mo, tb, vb} <= 3'b000;
      cyc_wait(4);
      flags(32'h270, 32'h270);
      recover(1'b0);
      bus(1'b1, `REG_CONFIG, 32'h200);
      @(posedge clk_sys_in);
      mo <= 1'b1;
      @(posedge clk_sys_in);
      mo <= 1'b0;
      cyc_wait(4);
      flags(32'h10, 32'h0);
      chk(32'(nl_seen), 32'h1);
      $display("format errors done");
      bus(1'b1, `REG_CONFIG, 32'h4);
      btn(1'b0);
      chk({dtr, 28'(rs)}, {1'b0, 28'(ST_STOP)});
      q(`CODE_STOP, 1'b1);
      btn(1'b0);
      chk({dtr, 28'(rs)}, {1'b1, 28'(ST_RUN)});
      // Frozen block must ignore a button press
      en <= 1'b0;
      btn(1'b0);
      en <= 1'b1;
      cyc_wait(8);
      chk(32'(rs), 32'(ST_RUN));
      $display("freeze done");
      repeat (40) begin
         lvl <= 12'($urandom_range(1700));
         rnd = 8'($urandom);
         rx(rnd, 3'h0);
         chk(32'(last_wd), 32'(rnd));
      end
      $display("stream done");
      print_verdict();
   end
endmodule : testbench
